// >>> src/pos_cmd_map.svh
// Purpose: Scale factors, field codes, reset values and timing counts of the position command source.
// Assumes: A 200 MHz core clock.
// Notes: Definitions only; included by bare name.
`ifndef POS_CMD_MAP_SVH
`define POS_CMD_MAP_SVH

// Digital input function codes for the three select bits and the trigger.
`define SEL_FN_BASE 7'h0B
`define TRIG_FN 7'h08

// One motor revolution in counts.
`define COUNTS_PER_REV 32'h0000_2710

`define POS_RESET 32'h0000_0000
`define POS_MODE_ABS 1'b0

// Smoothing moves one eighth of the remaining error per step.
`define SMOOTH_SHIFT 3

// Percent scaling of the feed-forward term: 41 / 4096 is close to 1 / 100.
`define FF_PCT_MUL 16'h0029
`define FF_PCT_SHIFT 12

// A step every setting x 1.25 ms gives a time constant of about setting x 10 ms.
`define CLK_PERIOD_NS 5
`define SMOOTH_UNIT_NS 1250000
`define SMOOTH_UNIT_CYC (`SMOOTH_UNIT_NS / `CLK_PERIOD_NS)

`endif

// >>> src/pos_cmd_pkg.sv
// Purpose: Types shared by the position command source and its bench.
// Assumes: Eight targets, eight input terminals.
// Notes: Numeric constants live in pos_cmd_map.svh.
package pos_cmd_pkg;

    typedef logic signed [31:0] pos_t;

    typedef enum logic [1:0] {
        PULSE_DIR = 2'b00,
        CW_CCW = 2'b01,
        QUADRATURE = 2'b10
    } pulse_fmt_e;

    // Function code of each digital input terminal.
    typedef logic [7:0][6:0] fn_assign_t;

    typedef struct packed {
        logic [7:0][15:0] target_revs_word;
        logic [7:0][15:0] target_counts_word;
    } target_table_s;

    typedef struct packed {
        logic [15:0] pos_gain_setting;
        logic [7:0] feedforward_setting;
        logic [31:0] pos_err_limit;
    } loop_gain_s;

endpackage : pos_cmd_pkg

// >>> src/position_command_source.sv
// Purpose: Position command front end: pulse-train decode, eight-target indexer, smoothing,
// Purpose: proportional plus feed-forward position loop and following-error fault.
// Assumes: Pins and input terminals are asynchronous; motor_pos and load_excess are on clk.
// Notes: pulse_train_mode high selects pulse-train mode, low selects indexer mode.
// Operation
// R1 - Command position is smoothed by a low-pass filter, bypassed when the setting is zero.
// R2 - Pulse trains are decoded as pulse plus direction, CW/CCW or quadrature, with polarity.
// R3 - Pulse inputs accept up to 200kpps open-collector and 500kpps line-driver rates.
// R4 - Eight targets are held in 16 words, one revolution word and one count word each.
// R5 - A target is revolutions times 10,000 plus the signed count word.
// R6 - The three select bits form a binary code, 000 for target one and 111 for target eight.
// R7 - Each select function can sit on any input terminal via function codes 11 to 13.
// R8 - A move starts only on an inactive-to-active edge of the trigger input.
// R9 - The positioning setting picks absolute targets at 0 and incremental targets at 1.
// R10 - In absolute mode the command becomes the target, whatever it was before.
// R11 - In incremental mode the target is added to the present command position.
// R12 - The loop applies a proportional gain on error plus a feed-forward gain in percent.
// R13 - The velocity loop gain should be at least four times the position loop gain.
// R14 - A fault is raised on excessive following error or on motor overload.
// R15 - The controller holds the select inputs stable for 1ms before the trigger.
// R16 - The select code is latched at the trigger edge and held until the next one.
`include "pos_cmd_map.svh"

module position_command_source #(
    parameter int unsigned SMOOTH_UNIT_CYC = `SMOOTH_UNIT_CYC
) (
    input logic clk,
    input logic resetn,
    input logic pin_a,
    input logic pin_b,
    input logic [7:0] di_pins,
    input logic pulse_train_mode,
    input pos_cmd_pkg::pulse_fmt_e pulse_format_select,
    input logic pulse_polarity,
    input logic abs_incr_select,
    input logic [9:0] smooth_filter_setting,
    input pos_cmd_pkg::fn_assign_t input_function_assign,
    input pos_cmd_pkg::target_table_s targets,
    input pos_cmd_pkg::loop_gain_s gains,
    input pos_cmd_pkg::pos_t motor_pos,
    input logic load_excess,
    input logic fault_clear,
    output pos_cmd_pkg::pos_t cmd_pos,
    output pos_cmd_pkg::pos_t smooth_pos,
    output pos_cmd_pkg::pos_t vel_cmd,
    output logic pos_fault,
    output logic [2:0] target_index,
    output logic move_start
);
    import pos_cmd_pkg::*;

    // True when any active terminal carries the given function code.
    function automatic logic fn_active(input fn_assign_t assign_map, input logic [7:0] level,
                                       input logic [6:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            hit = hit | (level[i] & (assign_map[i] == code));
        end
        return hit;
    endfunction : fn_active

    // Input synchronisers: a change is taken once the second and third stages agree.
    logic [9:0] s1_q, s2_q, s3_q, stab_q, prev_q;
    logic [9:0] stab_d;

    always_comb
    begin
        stab_d = ((s2_q ~^ s3_q) & s2_q) | ((s2_q ^ s3_q) & stab_q);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_q <= 10'h000;
            s2_q <= 10'h000;
            s3_q <= 10'h000;
            stab_q <= 10'h000;
            prev_q <= 10'h000;
        end
        else
        begin
            s1_q <= {di_pins, pin_b, pin_a};
            s2_q <= s1_q;
            s3_q <= s2_q;
            stab_q <= stab_d;
            prev_q <= stab_q;
        end
    end

    // Pulse decode and indexer decode.
    logic a_now, b_now, a_old, b_old, a_rise, b_rise;
    logic [2:0] sel_code;
    logic trig_now, trig_old, trig_edge;
    logic signed [1:0] step;
    pos_t target_pos, rev_sel, cnt_sel;

    always_comb
    begin
        // R2 polarity and edges
        a_now = stab_q[0] ^ pulse_polarity;
        b_now = stab_q[1] ^ pulse_polarity;
        a_old = prev_q[0] ^ pulse_polarity;
        b_old = prev_q[1] ^ pulse_polarity;
        a_rise = a_now & ~a_old;
        b_rise = b_now & ~b_old;
        step = 2'sd0;
        // R2 format decode
        unique case (pulse_format_select)
            PULSE_DIR:
                if (a_rise)
                    step = b_now ? -2'sd1 : 2'sd1;
            CW_CCW:
                if (a_rise != b_rise)
                    step = a_rise ? 2'sd1 : -2'sd1;
            QUADRATURE:
                if ((a_now != a_old) != (b_now != b_old))
                    step = (a_now ^ b_old) ? 2'sd1 : -2'sd1;
            default:
                step = 2'sd0;
        endcase
        // R7 select functions on any terminal
        sel_code[0] = fn_active(input_function_assign, stab_q[9:2], `SEL_FN_BASE);
        sel_code[1] = fn_active(input_function_assign, stab_q[9:2], `SEL_FN_BASE + 7'h01);
        sel_code[2] = fn_active(input_function_assign, stab_q[9:2], `SEL_FN_BASE + 7'h02);
        trig_now = fn_active(input_function_assign, stab_q[9:2], `TRIG_FN);
        trig_old = fn_active(input_function_assign, prev_q[9:2], `TRIG_FN);
        // R8 trigger edge only
        trig_edge = trig_now & ~trig_old & ~pulse_train_mode;
        // R4 R5 R6 target word pair by binary code
        rev_sel = 32'(signed'(targets.target_revs_word[sel_code]));
        cnt_sel = 32'(signed'(targets.target_counts_word[sel_code]));
        target_pos = 32'(rev_sel * signed'(`COUNTS_PER_REV)) + cnt_sel;
    end

    // Command position.
    pos_t cmd_pos_q, cmd_pos_d;
    logic [2:0] target_index_q, target_index_d;
    logic move_start_q, move_start_d;

    always_comb
    begin
        cmd_pos_d = cmd_pos_q;
        target_index_d = target_index_q;
        move_start_d = 1'b0;
        if (pulse_train_mode)
        begin
            // R3 one count per clock is far above 500kpps
            cmd_pos_d = cmd_pos_q + 32'(step);
        end
        else if (trig_edge)
        begin
            // R16 latch selection at trigger
            target_index_d = sel_code;
            move_start_d = 1'b1;
            // R9 R10 R11 absolute or incremental
            if (abs_incr_select == `POS_MODE_ABS)
                cmd_pos_d = target_pos;
            else
                cmd_pos_d = cmd_pos_q + target_pos;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cmd_pos_q <= `POS_RESET;
            target_index_q <= 3'h0;
            move_start_q <= 1'b0;
        end
        else
        begin
            cmd_pos_q <= cmd_pos_d;
            target_index_q <= target_index_d;
            move_start_q <= move_start_d;
        end
    end

    // Smoothing filter: a nudge toward the target is forced when the shifted error is zero,
    // otherwise the output would stall a few counts short.
    pos_t smooth_q, smooth_d, smooth_prev_q;
    logic [31:0] tick_cnt_q, tick_cnt_d, tick_len;
    logic signed [32:0] sm_err, sm_step;

    always_comb
    begin
        tick_len = 32'(smooth_filter_setting) * SMOOTH_UNIT_CYC;
        sm_err = 33'(cmd_pos_q) - 33'(smooth_q);
        sm_step = sm_err >>> `SMOOTH_SHIFT;
        if (sm_step == 33'sd0 && sm_err != 33'sd0)
            sm_step = sm_err[32] ? -33'sd1 : 33'sd1;
        tick_cnt_d = tick_cnt_q + 32'h0000_0001;
        smooth_d = smooth_q;
        // R1 bypass or step
        if (smooth_filter_setting == 10'h000)
        begin
            tick_cnt_d = 32'h0000_0000;
            smooth_d = cmd_pos_q;
        end
        else if (tick_cnt_q >= tick_len - 32'h0000_0001)
        begin
            tick_cnt_d = 32'h0000_0000;
            smooth_d = 32'(33'(smooth_q) + sm_step);
        end
    end

    // Position loop and fault.
    pos_t vel_cmd_q, vel_cmd_d;
    logic pos_fault_q, pos_fault_d;
    logic signed [32:0] loop_err;
    logic [32:0] err_mag;
    logic signed [63:0] p_term, ff_term;

    always_comb
    begin
        loop_err = 33'(smooth_q) - 33'(motor_pos);
        err_mag = loop_err[32] ? 33'(-loop_err) : 33'(loop_err);
        // R12 proportional plus feed-forward
        p_term = 64'(loop_err) * 64'(signed'({1'b0, gains.pos_gain_setting}));
        ff_term = (64'(smooth_q - smooth_prev_q) * 64'(signed'({1'b0, gains.feedforward_setting}))
                   * 64'(signed'({1'b0, `FF_PCT_MUL}))) >>> `FF_PCT_SHIFT;
        vel_cmd_d = 32'(p_term + ff_term);
        // R14 fault set wins over clear
        pos_fault_d = (err_mag > {1'b0, gains.pos_err_limit}) | load_excess
                      | (pos_fault_q & ~fault_clear);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            smooth_q <= `POS_RESET;
            smooth_prev_q <= `POS_RESET;
            tick_cnt_q <= 32'h0000_0000;
            vel_cmd_q <= `POS_RESET;
            pos_fault_q <= 1'b0;
        end
        else
        begin
            smooth_q <= smooth_d;
            smooth_prev_q <= smooth_q;
            tick_cnt_q <= tick_cnt_d;
            vel_cmd_q <= vel_cmd_d;
            pos_fault_q <= pos_fault_d;
        end
    end

    assign cmd_pos = cmd_pos_q;
    assign smooth_pos = smooth_q;
    assign vel_cmd = vel_cmd_q;
    assign pos_fault = pos_fault_q;
    assign target_index = target_index_q;
    assign move_start = move_start_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_trigger;
        trig_edge;
    endsequence
    sequence s_started;
        move_start_q && !$stable(target_index_q) || move_start_q;
    endsequence

    property p_smooth_bypass;
        smooth_filter_setting == 10'h000 |=> smooth_q == $past(cmd_pos_q);
    endproperty
    a_smooth_bypass: assert property (p_smooth_bypass) else $error("filter not bypassed"); // R1

    property p_pd_step;
        pulse_train_mode && pulse_format_select == PULSE_DIR && a_rise && !b_now
            |=> cmd_pos_q == $past(cmd_pos_q) + 32'sd1;
    endproperty
    a_pd_step: assert property (p_pd_step) else $error("pulse plus direction miscounted"); // R2

    property p_rate;
        pulse_train_mode |=> (cmd_pos_q - $past(cmd_pos_q)) inside {-32'sd1, 32'sd0, 32'sd1};
    endproperty
    a_rate: assert property (p_rate) else $error("more than one count per cycle"); // R3

    property p_abs_target;
        s_trigger and !abs_incr_select
            |=> cmd_pos_q == 32'($past(rev_sel) * 32'sd10000 + $past(cnt_sel));
    endproperty
    a_abs_target: assert property (p_abs_target) else $error("absolute target wrong"); // R10

    property p_incr_target;
        s_trigger and abs_incr_select |=> cmd_pos_q == $past(cmd_pos_q) + $past(target_pos);
    endproperty
    a_incr_target: assert property (p_incr_target) else $error("incremental sum wrong"); // R11

    property p_sel_latch;
        s_trigger |=> s_started ##0 target_index_q == $past(sel_code);
    endproperty
    a_sel_latch: assert property (p_sel_latch) else $error("selection not latched"); // R16

    property p_sel_hold;
        !trig_edge |=> $stable(target_index_q) && !move_start_q;
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("selection moved without edge"); // R16

    property p_no_level_start;
        trig_now && trig_old |=> !move_start_q;
    endproperty
    a_no_level_start: assert property (p_no_level_start) else $error("start on level"); // R8

    property p_fault_set;
        err_mag > {1'b0, gains.pos_err_limit} && fault_clear |=> pos_fault_q;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault lost on clear"); // R14

    property p_fault_hold;
        pos_fault_q && !fault_clear |=> pos_fault_q;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault dropped"); // R14

endmodule : position_command_source

// >>> tb/motion_ctrl_model.sv
// Purpose: Behavioural motion controller that drives the pulse pins and input terminals.
// Assumes: Everything changes just after a falling clock edge.
// Notes: Select hold and edge spacing are parameters so that the run stays short.
module motion_ctrl_model #(
    parameter int SEL_HOLD_CYC = 200000,
    parameter int EDGE_GAP_CYC = 200
) (
    input wire logic clk,
    input wire logic pol,
    output logic pin_a,
    output logic pin_b,
    output logic [7:0] di_pins = 8'h00
);
    logic a_l = 1'b0;
    logic b_l = 1'b0;
    logic [1:0] quad_idx = 2'h0;
    assign pin_a = a_l ^ pol;
    assign pin_b = b_l ^ pol;

    task automatic gap();
        repeat (EDGE_GAP_CYC) @(negedge clk);
    endtask : gap

    // One command count; quadrature phases run 00, 10, 11, 01 going forward.
    task automatic step(input logic [1:0] fmt, input logic fwd);
        if (fmt == 2'h2)
        begin
            quad_idx = fwd ? quad_idx + 2'h1 : quad_idx - 2'h1;
            a_l = quad_idx[1] ^ quad_idx[0];
            b_l = quad_idx[1];
        end
        else
        begin
            if (fmt != 2'h1)
                b_l = ~fwd;
            gap();
            if (fmt == 2'h1 && !fwd)
                b_l = 1'b1;
            else
                a_l = 1'b1;
            gap();
            a_l = 1'b0;
            if (fmt == 2'h1)
                b_l = 1'b0;
        end
        gap();
    endtask : step

    // Selects sit on terminals 5, 2 and 7.
    task automatic set_sel(input logic [2:0] code);
        di_pins[5] = code[0];
        di_pins[2] = code[1];
        di_pins[7] = code[2];
    endtask : set_sel

    task automatic select_and_fire(input logic [2:0] code);
        set_sel(code);
        repeat (SEL_HOLD_CYC) @(negedge clk);
        di_pins[0] = 1'b1;
    endtask : select_and_fire

    task automatic drop_trigger();
        di_pins[0] = 1'b0;
        gap();
    endtask : drop_trigger
endmodule : motion_ctrl_model

// >>> tb/position_command_source_bench.sv
// Purpose: Self-checking bench for the position command source.
// Assumes: Smoothing unit shortened to 4 cycles.
// Notes: Inputs change on falling edges only.
`include "pos_cmd_map.svh"
module position_command_source_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pos_cmd_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic pin_a;
    logic pin_b;
    logic [7:0] di_pins;
    logic pulse_train_mode = 1'b0;
    pulse_fmt_e pulse_format_select = PULSE_DIR;
    logic pulse_polarity = 1'b0;
    logic abs_incr_select = 1'b0;
    logic [9:0] smooth_filter_setting = 10'h000;
    fn_assign_t input_function_assign;
    target_table_s targets;
    loop_gain_s gains;
    pos_t motor_pos = 32'h0000_0000;
    logic load_excess = 1'b0;
    logic fault_clear = 1'b0;
    pos_t cmd_pos;
    pos_t smooth_pos;
    pos_t vel_cmd;
    pos_t base;
    logic pos_fault;
    logic [2:0] target_index;
    logic move_start;
    logic [15:0] vel_gain_setting = 16'h000C;
    int err_total = 0;
    int compares = 0;

    always #2.5 clk = ~clk;

    motion_ctrl_model #(.SEL_HOLD_CYC(16), .EDGE_GAP_CYC(200)) mc (.clk(clk),
        .pol(pulse_polarity), .pin_a(pin_a), .pin_b(pin_b), .di_pins(di_pins));

    position_command_source #(.SMOOTH_UNIT_CYC(4)) uut (.clk(clk), .resetn(resetn),
        .pin_a(pin_a), .pin_b(pin_b), .di_pins(di_pins), .pulse_train_mode(pulse_train_mode),
        .pulse_format_select(pulse_format_select), .pulse_polarity(pulse_polarity),
        .abs_incr_select(abs_incr_select), .smooth_filter_setting(smooth_filter_setting),
        .input_function_assign(input_function_assign), .targets(targets), .gains(gains),
        .motor_pos(motor_pos), .load_excess(load_excess), .fault_clear(fault_clear),
        .cmd_pos(cmd_pos), .smooth_pos(smooth_pos), .vel_cmd(vel_cmd), .pos_fault(pos_fault),
        .target_index(target_index), .move_start(move_start));

    function automatic pos_t tgt(input int i);
        return pos_t'((4 - 2 * i) * `COUNTS_PER_REV + (1000 * i - 5000));
    endfunction : tgt

    task automatic end_of_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic check(input pos_t got, input pos_t exp, input string what);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : check

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask : cycles

    task automatic fire(input logic [2:0] code);
        int n;
        n = 0;
        mc.select_and_fire(code);
        while (move_start !== 1'b1 && n < 12)
        begin
            @(negedge clk);
            n++;
        end
        check(pos_t'(move_start), 1, "move start");
    endtask : fire

    initial
    begin
        #400000;
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial
    begin
        input_function_assign = '0;
        input_function_assign[5] = `SEL_FN_BASE;
        input_function_assign[2] = `SEL_FN_BASE + 7'h01;
        input_function_assign[7] = `SEL_FN_BASE + 7'h02;
        input_function_assign[0] = `TRIG_FN;
        for (int i = 0; i < 8; i++)
        begin
            targets.target_revs_word[i] = 16'(4 - 2 * i);
            targets.target_counts_word[i] = 16'(1000 * i - 5000);
        end
        gains = '{16'h0003, 8'h64, 32'hFFFF_FFFF};
        check(pos_t'(vel_gain_setting >= 4 * gains.pos_gain_setting), 1, "gain ratio");
        cycles(8);
        resetn = 1'b1;
        @(negedge clk);
        check(cmd_pos, 0, "reset position");
        for (int i = 0; i < 8; i++)
        begin
            fire(3'(i));
            check(cmd_pos, tgt(i), "absolute target");
            check(pos_t'(target_index), i, "index");
            @(negedge clk);
            check(pos_t'(move_start), 0, "start width");
            check(smooth_pos, tgt(i), "bypass");
            mc.set_sel(~3'(i));
            cycles(20);
            check(pos_t'(target_index), i, "latched index");
            check(cmd_pos, tgt(i), "held trigger");
            mc.drop_trigger();
        end
        abs_incr_select = 1'b1;
        for (int k = 1; k <= 2; k++)
        begin
            fire(3'h1);
            check(cmd_pos, tgt(7) + pos_t'(k) * tgt(1), "incremental");
            mc.drop_trigger();
        end
        smooth_filter_setting = 10'h001;
        fire(3'h1);
        @(negedge clk);
        check(pos_t'(smooth_pos != cmd_pos), 1, "filter lag");
        cycles(1000);
        check(smooth_pos, cmd_pos, "filter settle");
        mc.drop_trigger();
        smooth_filter_setting = 10'h000;
        motor_pos = cmd_pos - 100;
        cycles(3);
        check(vel_cmd, 300, "loop gain");
        gains.pos_err_limit = 32'h0000_03E8;
        motor_pos = cmd_pos - 1001;
        cycles(3);
        check(pos_t'(pos_fault), 1, "error fault");
        fault_clear = 1'b1;
        cycles(3);
        check(pos_t'(pos_fault), 1, "set wins");
        motor_pos = cmd_pos - 1000;
        cycles(3);
        check(pos_t'(pos_fault), 0, "limit edge");
        check(vel_cmd, 3000, "loop gain");
        fault_clear = 1'b0;
        load_excess = 1'b1;
        cycles(3);
        check(pos_t'(pos_fault), 1, "overload");
        load_excess = 1'b0;
        pulse_train_mode = 1'b1;
        for (int f = 0; f < 4; f++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                pulse_format_select = pulse_fmt_e'(f);
                pulse_polarity = p[0];
                cycles(8);
                base = cmd_pos;
                repeat (5) mc.step(2'(f), 1'b1);
                mc.step(2'(f), 1'b0);
                cycles(8);
                check(cmd_pos, base + ((f == 3) ? 0 : 4), "pulse count");
            end
        end
        end_of_test();
    end
endmodule : position_command_source_bench
